// ==== core/card_fifo_control.sv ====
// Purpose: data queue control between system side and card data path
// Assumes: DEPTH_BYTES is a power of two and at least 32
// Notes: register port with read data one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module card_fifo_control #(
	parameter int DEPTH_BYTES = card_fifo_pkg::DEPTH_DEFAULT
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [card_fifo_pkg::REG_AW-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic sys_wr,
	input wire logic [31:0] sys_wdata,
	input wire logic sys_rd,
	output logic [31:0] sys_rdata,
	output logic sys_rvalid,
	output logic sys_full,
	output logic sys_empty,
	input wire logic card_in_valid,
	input wire logic [7:0] card_in_byte,
	output logic card_in_ready,
	input wire logic card_out_take,
	output logic [7:0] card_out_byte,
	output logic card_out_valid,
	output logic card_out_avail,
	output logic dma_controller_request,
	output logic threshold_irq
);
	import card_fifo_pkg::*;
	localparam int PW = $clog2(DEPTH_BYTES);
	localparam int CW = PW + 1;
	localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH_BYTES);
	localparam logic [CW-1:0] ZERO_C = '0;
	localparam logic [CW-1:0] ONE_C = CW'(1);

	// ************************************************
	// reset release
	// ************************************************
	logic rst_meta_reg;
	logic rst_sync_reg;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// ************************************************
	// decode functions
	// ************************************************
	function automatic logic [2:0] width_bytes(input logic [1:0] sel);
		case (sel)
			ACC_4B: return BYTES_4;
			ACC_3B: return BYTES_3;
			ACC_2B: return BYTES_2;
			default: return BYTES_1;
		endcase
	endfunction

	function automatic logic [CW-1:0] thr_bytes(input logic lev);
		return lev ? CW'(THR_HIGH_BITS / BYTE_W) : CW'(THR_LOW_BITS / BYTE_W);
	endfunction

	// ************************************************
	// control register and state
	// ************************************************
	logic [CTL_W-1:0] ctrl_reg;
	queue_state_t state_reg;
	queue_state_t state_next;
	wire logic ctl_rst = ctrl_reg[CTL_RST_BIT];
	wire logic ctl_dir = ctrl_reg[CTL_DIR_BIT];
	wire logic ctl_lev = ctrl_reg[CTL_LEV_BIT];
	wire logic [1:0] acc_sel = ctrl_reg[CTL_ACC_HI:CTL_ACC_LO];
	wire logic wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);

	always_comb begin
		case (state_reg)
			ST_HELD: state_next = ctl_rst ? ST_HELD : ST_RUN;
			ST_RUN: state_next = ctl_rst ? ST_HELD : ST_RUN;
			default: state_next = ST_HELD;
		endcase
	end

	// held while the queue reset bit stands
	wire logic running = (state_reg == ST_RUN) && !ctl_rst;

	// ************************************************
	// transfer qualification
	// ************************************************
	logic [CW-1:0] count_reg;
	logic [PW-1:0] wptr_reg;
	logic [PW-1:0] rptr_reg;
	logic full_reg;
	logic empty_reg;
	logic [7:0] mem [DEPTH_BYTES];
	wire logic [2:0] wb = width_bytes(acc_sel);
	wire logic [CW-1:0] wc = CW'(wb);
	wire logic [CW-1:0] thr = thr_bytes(ctl_lev);
	wire logic [CW-1:0] free_c = DEPTH_C - count_reg;
	// system side moves data one way only
	wire logic sys_push = running && ctl_dir && sys_wr && !full_reg;
	wire logic sys_pop = running && !ctl_dir && sys_rd && !empty_reg;
	wire logic card_push = running && !ctl_dir && card_in_valid && (count_reg != DEPTH_C);
	wire logic card_pop = running && ctl_dir && card_out_take && (count_reg != ZERO_C);
	wire logic [CW-1:0] sys_n = (sys_push || sys_pop) ? wc : ZERO_C;
	wire logic [CW-1:0] push_n = sys_push ? wc : (card_push ? ONE_C : ZERO_C);
	wire logic [CW-1:0] pop_n = sys_pop ? wc : (card_pop ? ONE_C : ZERO_C);
	wire logic [CW-1:0] count_next = running ? (count_reg + push_n - pop_n) : ZERO_C;
	wire logic [PW-1:0] wptr_next = running ? (wptr_reg + push_n[PW-1:0]) : '0;
	wire logic [PW-1:0] rptr_next = running ? (rptr_reg + pop_n[PW-1:0]) : '0;
	// flags judged against the width in force next cycle
	wire logic [CW-1:0] wc_next = wr_ctrl ?
		CW'(width_bytes(reg_wdata[CTL_ACC_HI:CTL_ACC_LO])) : wc;
	wire logic full_next = (DEPTH_C - count_next) < wc_next;
	wire logic empty_next = count_next < wc_next;

	// ************************************************
	// storage and read assembly
	// ************************************************
	logic [31:0] rd_word;
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			wire logic [PW-1:0] ra = rptr_reg + PW'(g);
			assign rd_word[g*BYTE_W +: BYTE_W] = (g < wb) ? mem[ra] : 8'h00;
		end
	endgenerate

	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < LANES; i++) begin
			if (sys_push && (i < wb)) begin
				mem[PW'(wptr_reg + PW'(i))] <= sys_wdata[i*BYTE_W +: BYTE_W];
			end
		end
		if (card_push) begin
			mem[wptr_reg] <= card_in_byte;
		end
	end

	// ************************************************
	// request pacing
	// ************************************************
	logic pend_reg;
	logic [CW-1:0] remain_reg;
	logic dma_req_reg;
	logic thr_irq_reg;
	wire logic room_ok = ctl_dir ? (free_c >= thr) : (count_reg >= thr);
	wire logic issue = running && !pend_reg && room_ok;
	wire logic [CW-1:0] remain_dec = (remain_reg > sys_n) ? (remain_reg - sys_n) : ZERO_C;
	wire logic pend_next = running && (issue || (pend_reg && (remain_dec != ZERO_C)));
	wire logic [CW-1:0] remain_next = !running ? ZERO_C : (issue ? thr : remain_dec);

	// ************************************************
	// register read path
	// ************************************************
	localparam int STAT_PAD = 32 - STAT_CNT_LO - CW;
	wire logic [31:0] stat_word = {{STAT_PAD{1'b0}}, count_reg, {(STAT_CNT_LO - 3){1'b0}},
		pend_reg, full_reg, empty_reg};
	wire logic [31:0] ctrl_word = {{(32 - CTL_W){1'b0}}, ctrl_reg};
	wire logic [31:0] rdata_next = !reg_rd ? 32'h0000_0000 :
		(reg_addr == OFS_CTRL) ? ctrl_word :
		(reg_addr == OFS_STAT) ? stat_word : 32'h0000_0000;

	// ************************************************
	// sequential state
	// ************************************************
	logic [31:0] reg_rdata_reg;
	logic [31:0] sys_rdata_reg;
	logic sys_rvalid_reg;
	logic [7:0] card_byte_reg;
	logic card_valid_reg;
	logic card_ready_reg;
	logic card_avail_reg;

	always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			ctrl_reg <= CTL_RESET;
			state_reg <= ST_HELD;
			reg_rdata_reg <= 32'h0000_0000;
		end else begin
			if (wr_ctrl) begin
				ctrl_reg <= reg_wdata[CTL_W-1:0];
			end
			state_reg <= state_next;
			reg_rdata_reg <= rdata_next;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			count_reg <= '0;
			wptr_reg <= '0;
			rptr_reg <= '0;
			full_reg <= 1'b0;
			empty_reg <= 1'b1;
			card_ready_reg <= 1'b0;
			card_avail_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			wptr_reg <= wptr_next;
			rptr_reg <= rptr_next;
			full_reg <= full_next;
			empty_reg <= empty_next;
			card_ready_reg <= running && !ctl_dir && (count_next != DEPTH_C);
			card_avail_reg <= running && ctl_dir && (count_next != ZERO_C);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			sys_rdata_reg <= 32'h0000_0000;
			sys_rvalid_reg <= 1'b0;
			card_byte_reg <= 8'h00;
			card_valid_reg <= 1'b0;
		end else begin
			if (sys_pop) begin
				sys_rdata_reg <= rd_word;
			end
			sys_rvalid_reg <= sys_pop;
			if (card_pop) begin
				card_byte_reg <= mem[rptr_reg];
			end
			card_valid_reg <= card_pop;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			pend_reg <= 1'b0;
			remain_reg <= '0;
			dma_req_reg <= 1'b0;
			thr_irq_reg <= 1'b0;
		end else begin
			pend_reg <= pend_next;
			remain_reg <= remain_next;
			dma_req_reg <= issue;
			thr_irq_reg <= issue;
		end
	end

	assign reg_rdata = reg_rdata_reg;
	assign sys_rdata = sys_rdata_reg;
	assign sys_rvalid = sys_rvalid_reg;
	assign sys_full = full_reg;
	assign sys_empty = empty_reg;
	assign card_in_ready = card_ready_reg;
	assign card_out_byte = card_byte_reg;
	assign card_out_valid = card_valid_reg;
	assign card_out_avail = card_avail_reg;
	assign dma_controller_request = dma_req_reg;
	assign threshold_irq = thr_irq_reg;

	// ************************************************
	// checks
	// ************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_sync_reg);

	a_push_room: assert property (sys_push |-> (free_c >= wc))
		else $error("system write accepted without room for access width");
	a_pop_fill: assert property (sys_pop |-> (count_reg >= wc))
		else $error("system read accepted with fewer bytes than access width");
	a_req_pair: assert property (dma_req_reg |-> thr_irq_reg && pend_reg)
		else $error("request and threshold event disagree");
	a_req_level: assert property (issue |=> (remain_reg == $past(thr)) && dma_req_reg)
		else $error("request not armed with threshold byte count");
	a_req_single: assert property (dma_req_reg |=> !dma_req_reg)
		else $error("second request before threshold bytes moved");
	a_dir_read: assert property (sys_rvalid_reg |-> !$past(ctl_dir))
		else $error("system read data while direction is write");
	a_held_clear: assert property (ctl_rst |=> (count_reg == ZERO_C) && empty_reg && !full_reg
		&& !pend_reg)
		else $error("queue state not cleared under queue reset");
	a_held_stay: assert property (ctl_rst && !wr_ctrl |=> ctl_rst ##1 (wptr_reg == '0))
		else $error("queue reset released without software write");
	a_fill_bound: assert property (count_reg <= DEPTH_C)
		else $error("byte count beyond queue depth");
	a_card_dir: assert property (card_valid_reg |-> $past(ctl_dir))
		else $error("card byte taken while direction is read");
	a_ready_dir: assert property (card_ready_reg |-> !$past(ctl_dir))
		else $error("card input ready while direction is write");

	c_full_hit: cover property (running && ctl_dir ##1 full_reg);
	c_read_req: cover property (!ctl_dir && dma_req_reg && ctl_lev);
	c_write_req: cover property (ctl_dir && dma_req_reg);
	c_reset_run: cover property (ctl_rst ##1 !ctl_rst ##[1:8] sys_rvalid_reg);
	c_narrow_fill: cover property (running && (wb == BYTES_1) ##1 !empty_reg);
endmodule // card_fifo_control
`default_nettype wire

// ==== core/card_fifo_pkg.sv ====
// Purpose: constants for the card data queue control block
// Assumes: byte-wide queue storage, 32-bit register and system data
// Notes: control register fields follow the access-width/level/direction/reset layout
`default_nettype none
package card_fifo_pkg;
	// ************************************************
	// register map
	// ************************************************
	localparam int REG_AW = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam int CTL_RST_BIT = 0;
	localparam int CTL_DIR_BIT = 1;
	localparam int CTL_LEV_BIT = 2;
	localparam int CTL_ACC_LO = 3;
	localparam int CTL_ACC_HI = 4;
	localparam int CTL_W = 5;
	localparam logic [4:0] CTL_RESET = 5'h00;
	localparam int STAT_CNT_LO = 8;
	// ************************************************
	// access width codes and byte counts
	// ************************************************
	localparam logic [1:0] ACC_4B = 2'h0;
	localparam logic [1:0] ACC_3B = 2'h1;
	localparam logic [1:0] ACC_2B = 2'h2;
	localparam logic [2:0] BYTES_4 = 3'h4;
	localparam logic [2:0] BYTES_3 = 3'h3;
	localparam logic [2:0] BYTES_2 = 3'h2;
	localparam logic [2:0] BYTES_1 = 3'h1;
	localparam int LANES = 4;
	localparam int BYTE_W = 8;
	// ************************************************
	// request thresholds
	// ************************************************
	localparam int THR_LOW_BITS = 128;
	localparam int THR_HIGH_BITS = 256;
	localparam int DEPTH_DEFAULT = 64;
	typedef enum logic [1:0] {
		ST_HELD = 2'b01,
		ST_RUN = 2'b10
	} queue_state_t;
endpackage
`default_nettype wire

// ==== tb/sys_master_model.sv ====
// Purpose: system-side master that answers queue requests with bursts
// Assumes: one burst per request, one access every other cycle
// Notes: released write data is inverted so stale values never match
`timescale 1ns/1ps
`default_nettype none
module sys_master_model (
	input wire logic clk_sys,
	input wire logic en,
	input wire logic dir,
	input wire logic [3:0] words,
	input wire logic req,
	input wire logic sys_full,
	input wire logic sys_empty,
	input wire logic sys_rvalid,
	input wire logic [31:0] sys_rdata,
	output logic sys_rd,
	output logic sys_wr,
	output logic [31:0] sys_wdata
);
	logic [31:0] got [0:15];
	int ngot = 0;
	int nput = 0;
	int left = 0;
	always @(posedge clk_sys) begin
		sys_rd <= 1'b0;
		sys_wr <= 1'b0;
		if (sys_rvalid) begin
			got[ngot[3:0]] <= sys_rdata;
			ngot <= ngot + 1;
		end
		if (left == 0) begin
			if (en && req) left <= 2 * words;
		end else begin
			left <= left - 1;
			// idle cycle gives the flags time to settle
			if (left[0] == 1'b0 && dir && !sys_full) begin
				sys_wr <= 1'b1;
				sys_wdata <= 32'h03020100 + nput * 32'h04040404;
				nput <= nput + 1;
			end else if (left[0] == 1'b0 && !dir && !sys_empty) begin
				sys_rd <= 1'b1;
			end else begin
				sys_wdata <= ~sys_wdata;
			end
		end
	end
endmodule // sys_master_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench for the card queue control block
// Assumes: default depth of 64 bytes
// Notes: card side driven here, system side by the master model
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
	import card_fifo_pkg::*;
	logic clk_sys = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00, card_in_byte = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, sys_wdata, sys_rdata, rd;
	logic sys_wr, sys_rd, sys_rvalid, sys_full, sys_empty, card_in_valid = 1'b0;
	logic card_in_ready, card_out_take = 1'b0, card_out_valid, card_out_avail;
	logic [7:0] card_out_byte;
	logic dma_controller_request, threshold_irq, en = 1'b0;
	logic [4:0] ctl = 5'h00;
	int mismatches = 0, checks = 0, nreq = 0;
	card_fifo_control uut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.sys_wr(sys_wr), .sys_wdata(sys_wdata), .sys_rd(sys_rd), .sys_rdata(sys_rdata),
		.sys_rvalid(sys_rvalid), .sys_full(sys_full), .sys_empty(sys_empty),
		.card_in_valid(card_in_valid), .card_in_byte(card_in_byte),
		.card_in_ready(card_in_ready), .card_out_take(card_out_take),
		.card_out_byte(card_out_byte), .card_out_valid(card_out_valid),
		.card_out_avail(card_out_avail), .dma_controller_request(dma_controller_request),
		.threshold_irq(threshold_irq));
	sys_master_model m (.clk_sys(clk_sys), .en(en), .dir(ctl[CTL_DIR_BIT]),
		.words(ctl[CTL_LEV_BIT] ? 4'h8 : 4'h4), .req(dma_controller_request),
		.sys_full(sys_full), .sys_empty(sys_empty), .sys_rvalid(sys_rvalid),
		.sys_rdata(sys_rdata), .sys_rd(sys_rd), .sys_wr(sys_wr), .sys_wdata(sys_wdata));
	initial begin
		forever #2.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (dma_controller_request === 1'b1) nreq++;
		`CHK(threshold_irq, dma_controller_request)
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		if (a == OFS_CTRL) ctl <= d[4:0];
	endtask
	task automatic rdr(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic push(input int n, input logic [7:0] base);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_sys);
			card_in_valid <= 1'b1;
			card_in_byte <= base + 8'(i);
		end
		@(posedge clk_sys);
		card_in_valid <= 1'b0;
	endtask
	task automatic settle(input int n);
		for (int i = 0; i < 300 && m.ngot < n; i++) @(posedge clk_sys);
		repeat (4) @(posedge clk_sys);
	endtask
	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk_sys);
		mismatches++;
		print_verdict();
	end
	initial begin
		repeat (5) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rdr(OFS_CTRL, rd);
		`CHK(rd, 32'h0)
		rdr(OFS_STAT, rd);
		`CHK(rd, 32'h1)
		rdr(8'h40, rd);
		`CHK(rd, 32'h0)
		wr(OFS_CTRL, 32'hffffffff);
		rdr(OFS_CTRL, rd);
		`CHK(rd, 32'h1f)
		wr(OFS_CTRL, 32'h0);
		$display("test 1 done");
		en <= 1'b1;
		push(16, 8'h10);
		settle(4);
		`CHK(nreq, 1)
		`CHK(m.got[0], 32'h13121110)
		`CHK(m.got[3], 32'h1f1e1d1c)
		rdr(OFS_STAT, rd);
		`CHK(rd, 32'h1)
		$display("test 2 done");
		wr(OFS_CTRL, 32'h4);
		push(31, 8'h20);
		repeat (4) @(posedge clk_sys);
		`CHK(nreq, 1)
		push(1, 8'h3f);
		settle(12);
		`CHK(nreq, 2)
		`CHK(m.got[11], 32'h3f3e3d3c)
		$display("test 3 done");
		en <= 1'b0;
		wr(OFS_CTRL, 32'h18);
		push(1, 8'h55);
		#1 `CHK(sys_empty, 1'b0)
		wr(OFS_CTRL, 32'h0);
		#1 `CHK(sys_empty, 1'b1)
		wr(OFS_CTRL, 32'h1);
		rdr(OFS_STAT, rd);
		`CHK(rd, 32'h1)
		`CHK(card_in_ready, 1'b0)
		wr(OFS_CTRL, 32'h2);
		$display("test 4 done");
		en <= 1'b1;
		repeat (40) @(posedge clk_sys);
		en <= 1'b0;
		repeat (20) @(posedge clk_sys);
		`CHK(card_out_avail, 1'b1)
		`CHK(sys_full, 1'b1)
		rdr(OFS_STAT, rd);
		`CHK(rd, 32'h4002)
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			card_out_take <= 1'b1;
			@(posedge clk_sys);
			card_out_take <= 1'b0;
			#1 `CHK({card_out_valid, card_out_byte}, {1'b1, 8'(i)})
		end
		`CHK(sys_full, 1'b0)
		$display("test 5 done");
		print_verdict();
	end
endmodule // tb_top
`default_nettype wire
